// ===== inc/ftsp_pkg.sv
// constants and types of the flow-through burst sram port
// What this block does
// - all synchronous inputs are sampled only on the rising clock edge.
// - clock enable high freezes every register but the pin sync flops and ignores inputs.
// - selected only when first and third selects low, second high.
// - deselect on a load cycle starts nothing and ends any burst.
// - a transfer already pending still completes after deselect.
// - data bus floats two cycles after a deselect or write start.
// - two-bit burst counter gives four data cycles per address.
// - advance_or_load low loads an address, high steps the counter.
// - burst mode input picks linear or interleaved order.
// - output enable and burst mode are asynchronous; oe gates outputs anytime.
// - reads and writes may follow each other with no idle cycle.
// - data bus split into data_in_i and data_out_o with data_oe_o, 18, 36 or 72 bits wide.
package ftsp_pkg;
	localparam int FTSP_ADDR_W_DEF  = 10;
	localparam int FTSP_LANES_DEF   = 4;
	localparam int FTSP_LANE_W      = 9;
	localparam int FTSP_BURST_W     = 2;
	localparam int FTSP_DATA_LAT    = 1;
	localparam int FTSP_Z_LAT       = 2;
	localparam logic FTSP_MODE_LIN  = 1'b0;
	typedef enum logic [1:0] {
		FTSP_OP_IDLE,
		FTSP_OP_READ,
		FTSP_OP_WRITE
	} ftsp_op_t;
endpackage

// ===== hdl/ftsp_mem.sv
// word-wide memory with per-lane write and registered read
`timescale 1ns/1ps
module ftsp_mem #(
	parameter int ADDR_W = 10,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	input  wire logic                      clk_i,
	input  wire logic                      rd_i,
	input  wire logic                      wr_i,
	input  wire logic [ADDR_W-1:0]         addr_i,
	input  wire logic [LANES-1:0]          lane_we_i,
	input  wire logic [LANES*LANE_W-1:0]   wdata_i,
	output logic      [LANES*LANE_W-1:0]   rdata_o
);
	logic [LANES*LANE_W-1:0] mem_r [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk_i) begin
		if (rd_i)
			rdata_o <= mem_r[addr_i];
		for (int l = 0; l < LANES; l++) begin
			if (wr_i && lane_we_i[l])
				mem_r[addr_i][l*LANE_W +: LANE_W] <= wdata_i[l*LANE_W +: LANE_W];
		end
	end
endmodule // ftsp_mem

// ===== hdl/ftsp_port.sv
// flow-through burst sram port: control, burst counter, data bus
`timescale 1ns/1ps
module ftsp_port
	import ftsp_pkg::*;
#(
	parameter int ADDR_W = FTSP_ADDR_W_DEF,
	parameter int LANES  = FTSP_LANES_DEF,
	localparam int DW    = LANES*FTSP_LANE_W
) (
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic              clock_enable_n_i,
	input  wire logic              chip_select_first_n_i,
	input  wire logic              chip_select_second_i,
	input  wire logic              chip_select_third_n_i,
	input  wire logic              advance_or_load_i,
	input  wire logic              write_en_n_i,
	input  wire logic [LANES-1:0]  byte_lane_write_sel_n_i,
	input  wire logic              output_en_n_i,
	input  wire logic              burst_mode_i,
	input  wire logic [DW-1:0]     data_in_i,
	output logic      [DW-1:0]     data_out_o,
	output logic                   data_oe_o
);
	// pins other than oe and mode pass two flops before use; the bus partner must account for it
	logic [1:0] cen_s, cs1_s, cs2_s, cs3_s, adv_s, we_s;
	logic [ADDR_W-1:0] addr_s0, addr_s1;
	logic [LANES-1:0]  bws_s0, bws_s1;
	logic [DW-1:0]     din_s0, din_s1;

	always_ff @(posedge clk_i) begin
		cen_s   <= {cen_s[0], clock_enable_n_i};
		cs1_s   <= {cs1_s[0], chip_select_first_n_i};
		cs2_s   <= {cs2_s[0], chip_select_second_i};
		cs3_s   <= {cs3_s[0], chip_select_third_n_i};
		adv_s   <= {adv_s[0], advance_or_load_i};
		we_s    <= {we_s[0], write_en_n_i};
		addr_s0 <= addr_i;
		addr_s1 <= addr_s0;
		bws_s0  <= byte_lane_write_sel_n_i;
		bws_s1  <= bws_s0;
		din_s0  <= data_in_i;
		din_s1  <= din_s0;
	end

	logic hold, sel, load, adv;
	assign hold = cen_s[1];
	assign sel  = !cs1_s[1] && cs2_s[1] && !cs3_s[1];
	assign load = !adv_s[1];
	assign adv  = adv_s[1];

	// burst state
	ftsp_op_t                 op_r, op_nxt;
	logic [ADDR_W-1:0]        base_r, base_nxt;
	logic [FTSP_BURST_W-1:0]  cnt_r, cnt_nxt;
	logic                     burst_r, burst_nxt;
	// data-phase pipeline: one stage for the operation, one for the bus
	ftsp_op_t                 dop_r, dop_nxt;
	logic [ADDR_W-1:0]        daddr_r, daddr_nxt;
	logic [LANES-1:0]         dbws_r, dbws_nxt;
	logic                     drv_r, drv_nxt;
	logic [FTSP_BURST_W-1:0]  seq;
	logic [ADDR_W-1:0]        eff_addr;

	// mode is not registered, so it steers the order combinationally
	always_comb begin
		if (burst_mode_i == FTSP_MODE_LIN)
			seq = base_r[FTSP_BURST_W-1:0] + cnt_r;
		else
			seq = base_r[FTSP_BURST_W-1:0] ^ cnt_r;
		eff_addr = {base_r[ADDR_W-1:FTSP_BURST_W], seq};
	end

	always_comb begin
		op_nxt    = op_r;
		base_nxt  = base_r;
		cnt_nxt   = cnt_r;
		burst_nxt = burst_r;
		dop_nxt   = dop_r;
		daddr_nxt = daddr_r;
		dbws_nxt  = dbws_r;
		drv_nxt   = drv_r;
		if (!hold) begin
			dop_nxt   = FTSP_OP_IDLE;
			daddr_nxt = eff_addr;
			dbws_nxt  = bws_s1;
			drv_nxt   = (dop_r == FTSP_OP_READ);
			if (load) begin
				if (sel) begin
					op_nxt    = we_s[1] ? FTSP_OP_READ : FTSP_OP_WRITE;
					base_nxt  = addr_s1;
					cnt_nxt   = '0;
					burst_nxt = 1'b1;
					dop_nxt   = op_nxt;
					daddr_nxt = addr_s1;
				end else begin
					op_nxt    = FTSP_OP_IDLE;
					burst_nxt = 1'b0;
				end
			end else if (adv && burst_r) begin
				cnt_nxt = cnt_r + 2'(1);
				dop_nxt = op_r;
				daddr_nxt = {base_r[ADDR_W-1:FTSP_BURST_W],
					(burst_mode_i == FTSP_MODE_LIN) ?
					2'(base_r[FTSP_BURST_W-1:0] + cnt_nxt) :
					(base_r[FTSP_BURST_W-1:0] ^ cnt_nxt)};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_r    <= FTSP_OP_IDLE;
			base_r  <= '0;
			cnt_r   <= '0;
			burst_r <= 1'b0;
			dop_r   <= FTSP_OP_IDLE;
			daddr_r <= '0;
			dbws_r  <= '1;
			drv_r   <= 1'b0;
		end else begin
			op_r    <= op_nxt;
			base_r  <= base_nxt;
			cnt_r   <= cnt_nxt;
			burst_r <= burst_nxt;
			dop_r   <= dop_nxt;
			daddr_r <= daddr_nxt;
			dbws_r  <= dbws_nxt;
			drv_r   <= drv_nxt;
		end
	end

	// pending data phase completes even if the next cycle deselects
	logic do_rd, do_wr;
	assign do_rd = !hold && dop_r == FTSP_OP_READ;
	assign do_wr = !hold && dop_r == FTSP_OP_WRITE;

	ftsp_mem #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (FTSP_LANE_W)
	) u_mem (
		.clk_i     (clk_i),
		.rd_i      (do_rd),
		.wr_i      (do_wr),
		.addr_i    (daddr_r),
		.lane_we_i (~dbws_r),
		.wdata_i   (din_s1),
		.rdata_o   (data_out_o)
	);

	assign data_oe_o = drv_r && !output_en_n_i;

	property p_hold_keeps;
		@(posedge clk_i) disable iff (sys_rst_i) hold |=> $stable(base_r) && $stable(cnt_r);
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("state moved under hold");
	property p_desel_ends;
		@(posedge clk_i) disable iff (sys_rst_i) (!hold && load && !sel) |=> !burst_r;
	endproperty
	a_desel_ends: assert property (p_desel_ends) else $error("burst not ended");
	property p_write_float;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel && !we_s[1]) ##1 !hold |=> !drv_r;
	endproperty
	a_write_float: assert property (p_write_float) else $error("bus driven after write");
	property p_cnt_step;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && adv && burst_r) |=> cnt_r == $past(cnt_r) + 2'd1;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");
	property p_load;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel) |=> base_r == $past(addr_s1) && cnt_r == 2'd0;
	endproperty
	a_load: assert property (p_load) else $error("address not loaded");
	property p_oe_async;
		@(posedge clk_i) disable iff (sys_rst_i) output_en_n_i |-> !data_oe_o;
	endproperty
	a_oe_async: assert property (p_oe_async) else $error("driving with oe off");
	property p_read_drive;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel && we_s[1]) ##1 !hold |=> drv_r;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
	property p_sel;
		@(posedge clk_i) disable iff (sys_rst_i) (!hold && load && !sel) |=> op_r == FTSP_OP_IDLE;
	endproperty
	a_sel: assert property (p_sel) else $error("op started while deselected");

	// pin sync depth is fixed at two; a deeper chain would shift every beat
	property p_sync_depth;
		@(posedge clk_i) disable iff (sys_rst_i)
			hold == $past(clock_enable_n_i, 2);
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("enable not two flops deep");

	// a frozen cycle must not disturb the data-phase pipeline either
	property p_hold_pipe;
		@(posedge clk_i) disable iff (sys_rst_i)
			hold |=> $stable(dop_r) && $stable(daddr_r) && $stable(drv_r);
	endproperty
	a_hold_pipe: assert property (p_hold_pipe) else $error("pipeline moved under hold");

	property p_hold_mem;
		@(posedge clk_i) disable iff (sys_rst_i)
			hold |-> !do_rd && !do_wr;
	endproperty
	a_hold_mem: assert property (p_hold_mem) else $error("memory accessed under hold");

	property p_desel_data;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && !sel) |=> dop_r == FTSP_OP_IDLE;
	endproperty
	a_desel_data: assert property (p_desel_data) else $error("data phase after deselect");

	property p_pend_read;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && dop_r == FTSP_OP_READ) |=> drv_r;
	endproperty
	a_pend_read: assert property (p_pend_read) else $error("pending read dropped");

	property p_desel_float;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && !sel) ##1 !hold |=> !drv_r;
	endproperty
	a_desel_float: assert property (p_desel_float) else $error("bus driven after deselect");

	property p_idle_float;
		@(posedge clk_i) disable iff (sys_rst_i)
			!drv_r |-> !data_oe_o;
	endproperty
	a_idle_float: assert property (p_idle_float) else $error("bus driven with no beat");

	property p_cnt_wrap;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && adv && burst_r && cnt_r == 2'd3) |=> cnt_r == 2'd0;
	endproperty
	a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap");

	property p_adv_beat;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && adv && burst_r) |=> dop_r == $past(op_r);
	endproperty
	a_adv_beat: assert property (p_adv_beat) else $error("advance gave no beat");

	property p_load_burst;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel) |=> burst_r;
	endproperty
	a_load_burst: assert property (p_load_burst) else $error("load did not open burst");

	// an advance with no open burst must be a no-op, not a stray beat
	property p_adv_idle;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && adv && !burst_r) |=> $stable(cnt_r) && dop_r == FTSP_OP_IDLE;
	endproperty
	a_adv_idle: assert property (p_adv_idle) else $error("advance outside burst acted");

	property p_load_addr;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel) |=> daddr_r == $past(addr_s1);
	endproperty
	a_load_addr: assert property (p_load_addr) else $error("first beat address wrong");

	property p_lin_order;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && adv && burst_r && burst_mode_i == FTSP_MODE_LIN) |=>
			daddr_r[1:0] == 2'($past(base_r[1:0]) + $past(cnt_r) + 2'd1);
	endproperty
	a_lin_order: assert property (p_lin_order) else $error("linear order wrong");

	property p_int_order;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && adv && burst_r && burst_mode_i != FTSP_MODE_LIN) |=>
			daddr_r[1:0] == ($past(base_r[1:0]) ^ 2'($past(cnt_r) + 2'd1));
	endproperty
	a_int_order: assert property (p_int_order) else $error("interleaved order wrong");

	property p_oe_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!output_en_n_i && drv_r) |-> data_oe_o;
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("read beat not driven");

	property p_read_op;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel && we_s[1]) |=> dop_r == FTSP_OP_READ;
	endproperty
	a_read_op: assert property (p_read_op) else $error("read not started");

	property p_write_op;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel && !we_s[1]) |=> dop_r == FTSP_OP_WRITE;
	endproperty
	a_write_op: assert property (p_write_op) else $error("write not started");

	// back to back loads must each open a data phase, no dead cycle between
	property p_no_gap;
		@(posedge clk_i) disable iff (sys_rst_i)
			(!hold && load && sel) ##1 (!hold && load && sel) |=> dop_r != FTSP_OP_IDLE;
	endproperty
	a_no_gap: assert property (p_no_gap) else $error("dead cycle between loads");

	c_inter: cover property (@(posedge clk_i) !hold && adv && burst_r && burst_mode_i);
	c_read:  cover property (@(posedge clk_i) do_rd ##1 drv_r);
	c_write: cover property (@(posedge clk_i) do_wr);
	c_burst: cover property (@(posedge clk_i) cnt_r == 2'd3);
	c_turn:  cover property (@(posedge clk_i) do_wr ##1 do_rd);
endmodule // ftsp_port

// ===== verif/ftsp_ctrl_model.sv
// controller-side model driving the port pins on falling edges
`timescale 1ns/1ps
module ftsp_ctrl_model #(
	parameter int AW = 10,
	parameter int LN = 4,
	parameter int DW = 36
) (
	input  wire logic     clk_i,
	output logic [AW-1:0] addr_o,
	output logic          cen_n_o,
	output logic [2:0]    cs_o,
	output logic          adv_o,
	output logic          we_n_o,
	output logic [LN-1:0] bw_n_o,
	output logic [DW-1:0] data_o
);
	logic [DW-1:0] pend = '0;
	initial {addr_o, cen_n_o, cs_o, adv_o, we_n_o, bw_n_o, data_o} = '1;
	task automatic cmd(input logic frz, ld, input logic [2:0] cs, input logic wr,
		input logic [AW-1:0] a, input logic [LN-1:0] bw, input logic [DW-1:0] d);
		@(negedge clk_i);
		cen_n_o = frz;
		cs_o = cs;
		adv_o = ld;
		we_n_o = !wr;
		addr_o = a;
		bw_n_o = bw;
		data_o = pend;
		// released bus shows the inverse, not a stale copy
		pend = wr ? d : ~pend;
	endtask
endmodule // ftsp_ctrl_model

// ===== verif/ftsp_port_tb.sv
// self-checking bench for the flow-through burst sram port
`timescale 1ns/1ps
module ftsp_port_tb
	import ftsp_pkg::*;
;
	localparam int AW = 10;
	localparam int LN = 4;
	localparam int DW = LN*FTSP_LANE_W;
	localparam logic [2:0] DESEL [3] = '{3'h6, 3'h0, 3'h3};
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          oe_n = 1'b0;
	logic          mode = FTSP_MODE_LIN;
	logic [AW-1:0] addr;
	logic [2:0]    cs;
	logic          cen_n, adv, we_n, doe;
	logic [LN-1:0] bw_n;
	logic [DW-1:0] din, dout, shadow [1<<AW], exp_q [$];
	int            mismatches = 0;
	int            check_count = 0;
	logic [31:0]   seed = 32'h2e;
	always #2.5 clk = ~clk;
	ftsp_port #(.ADDR_W(AW), .LANES(LN)) i_ftsp_port (.clk_i(clk), .sys_rst_i(rst),
		.addr_i(addr), .clock_enable_n_i(cen_n), .chip_select_first_n_i(cs[2]),
		.chip_select_second_i(cs[1]), .chip_select_third_n_i(cs[0]),
		.advance_or_load_i(adv), .write_en_n_i(we_n), .byte_lane_write_sel_n_i(bw_n),
		.output_en_n_i(oe_n), .burst_mode_i(mode), .data_in_i(din),
		.data_out_o(dout), .data_oe_o(doe));
	ftsp_ctrl_model #(.AW(AW), .LN(LN), .DW(DW)) i_ftsp_ctrl_model (.clk_i(clk),
		.addr_o(addr), .cen_n_o(cen_n), .cs_o(cs), .adv_o(adv), .we_n_o(we_n),
		.bw_n_o(bw_n), .data_o(din));
	function automatic logic [DW-1:0] rnd();
		for (int i = 0; i < 2; i++) begin
			seed ^= seed << 13;
			seed ^= seed >> 17;
			seed ^= seed << 5;
			rnd = {rnd[3:0], seed};
		end
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic fail(input string m);
		mismatches++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [DW-1:0] got, exp);
		check_count++;
		if (got !== exp) fail("value differs");
	endtask
	task automatic idle(input int n);
		repeat (n) i_ftsp_ctrl_model.cmd(1'b0, 1'b0, 3'h6, 1'b0, '0, '1, '0);
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [LN-1:0] bw);
		logic [DW-1:0] d;
		d = rnd();
		i_ftsp_ctrl_model.cmd(1'b0, 1'b0, 3'h2, 1'b1, a, bw, d);
		for (int l = 0; l < LN; l++) if (!bw[l]) shadow[a][l*9 +: 9] = d[l*9 +: 9];
	endtask
	task automatic rd(input logic [AW-1:0] a, input int n, input bit push);
		for (int k = 0; k < n; k++) begin
			// advance cycles carry junk addresses that must be ignored
			i_ftsp_ctrl_model.cmd(1'b0, k != 0, 3'h2, 1'b0, k ? AW'(rnd()) : a, '1, '0);
			if (push) exp_q.push_back(shadow[{a[AW-1:2],
				mode ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)}]);
		end
	endtask
	task automatic settle(input string name);
		idle(4);
		for (int i = 0; i < 20 && exp_q.size() != 0; i++) idle(1);
		if (exp_q.size() != 0) begin
			fail("beats missing");
			stop_test();
		end
		$display("test %s done", name);
	endtask
	always @(negedge clk) if (doe === 1'b1) begin
		if (exp_q.size() == 0) fail("stray beat");
		else chk(dout, exp_q.pop_front());
	end
	initial begin
		repeat (5) @(negedge clk);
		chk(DW'(doe), '0);
		rst = 1'b0;
		for (int i = 0; i < 16; i++) wr(AW'(i), '0);
		wr(10'h3, 4'ha);
		settle("write");
		rd(10'h5, 4, 1);
		rd(10'ha, 4, 1);
		settle("linear");
		mode = 1'b1;
		rd(10'h6, 4, 1);
		rd(10'h9, 4, 1);
		settle("interleave");
		mode = FTSP_MODE_LIN;
		rd(10'h3, 1, 1);
		wr(10'h3, 4'h5);
		rd(10'h3, 1, 1);
		wr(10'h4, 4'ha);
		rd(10'h4, 2, 1);
		settle("turnaround");
		for (int j = 0; j < 3; j++) begin
			rd(AW'(8 + j), 2, 1);
			i_ftsp_ctrl_model.cmd(1'b0, 1'b0, DESEL[j], 1'b0, '0, '1, '0);
			i_ftsp_ctrl_model.cmd(1'b0, 1'b1, 3'h2, 1'b0, '0, '1, '0);
		end
		settle("deselect");
		i_ftsp_ctrl_model.cmd(1'b1, 1'b0, 3'h2, 1'b1, 10'h7, '0, ~shadow[7]);
		idle(2);
		rd(10'h7, 1, 1);
		settle("freeze");
		oe_n = 1'b1;
		rd(10'h2, 4, 0);
		for (int i = 0; i < 8; i++) begin
			idle(1);
			chk(DW'(doe), '0);
		end
		oe_n = 1'b0;
		settle("output enable");
		stop_test();
	end
endmodule // ftsp_port_tb
